// >>> hw/ptc_top.sv
// ptp event trigger output and event timestamp input control
//
// Overview of operation
// RULE1 - arm bit starts unit, clears after firing
// RULE2 - software arms only the chain head
// RULE3 - trigger soft clear restores unit defaults
// RULE4 - trigger soft clear halts looping chain
// RULE5 - capture arm enables unit, zeroes tally
// RULE6 - capture disarm clears ready and overflow
// RULE7 - capture soft clear restores unit defaults
// RULE8 - trigger fields follow two-bit unit index
// RULE9 - capture fields follow one-bit unit index
// RULE10 - thirty-bit target nanoseconds, upper bits zero
// RULE11 - full-width target seconds, reset zero
// RULE12 - chain bit selects cascade operation
// RULE13 - tail bit marks last chain unit
// RULE14 - no tail means endless looping
// RULE15 - upstream select picks starting done signal
// RULE16 - late-fire bit fires past targets immediately
// RULE17 - notify bit gates done, error reports
// RULE18 - edge bit picks output clock edge
// RULE19 - armed unit fires at target time
// RULE20 - per-unit interrupt status, write one clears
// RULE21 - seconds and nanoseconds compared as one
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"

module ptc_top
   import ptc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire ptc_bus_req_t bus_i,
   output logic [31:0] rdata_o,
   input wire ptc_time_t ptp_time_i,
   input wire logic [`PTC_NUM_TS-1:0] ts_event_i,
   output logic [`PTC_NUM_TRIG-1:0] trig_out_o
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   ptc_state_t state_reg;
   ptc_state_t state_next;
   logic [`PTC_NUM_TRIG-1:0] fire_neg_reg;

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      logic [61:0] now;
      logic [61:0] tgt;
      logic [`PTC_NUM_TRIG-1:0] set_done;
      logic [`PTC_NUM_TRIG-1:0] set_err;
      logic [`PTC_NUM_TRIG-1:0] irq_clr;
      logic [1:0] up;
      logic ev;
      logic [31:0] rd;
      logic tsel_ok;
      ptc_trig_unit_t tsel;
      ptc_ts_unit_t ssel;
      now = {ptp_time_i.sec, ptp_time_i.ns[`PTC_NS_W-1:0]};
      tgt = '0;
      set_done = '0;
      set_err = '0;
      irq_clr = '0;
      up = 2'h0;
      ev = 1'b0;
      rd = `PTC_RST_WORD;
      tsel_ok = 1'b0;
      tsel = '0;
      ssel = '0;
      state_next = state_reg;
      state_next.rdata = `PTC_RST_WORD;

      // trigger units: compare, fire, cascade start
      for (int u = 0; u < `PTC_NUM_TRIG; u++) begin
         state_next.tu[u].fire = 1'b0;
         tgt = {state_reg.tu[u].tgt_s, state_reg.tu[u].tgt_ns}; // RULE21
         if (state_reg.tu[u].en) begin
            state_next.tu[u].fresh = 1'b0;
            if (now == tgt || (now > tgt && (!state_reg.tu[u].fresh ||
                state_reg.tu[u].cfg.late))) begin // RULE19 RULE16
               state_next.tu[u].en = 1'b0; // RULE1
               state_next.tu[u].fire = 1'b1;
               set_done[u] = state_reg.tu[u].cfg.notify; // RULE17
            end else if (now > tgt) begin
               // target already behind system time and late fire is off
               state_next.tu[u].en = 1'b0;
               set_err[u] = state_reg.tu[u].cfg.notify; // RULE17
            end
         end
         if (state_reg.tu[u].cfg.chain && state_reg.tu[u].cfg.upsel != 2'h0) begin // RULE12
            up = state_reg.tu[u].cfg.upsel - 2'h1; // RULE15
            // a tail upstream ends the pass, otherwise the chain keeps looping
            if (state_reg.tu[up].fire && !state_reg.tu[up].cfg.tail) begin // RULE13 RULE14
               state_next.tu[u].en = 1'b1;
               state_next.tu[u].fresh = 1'b1;
            end
         end
      end

      // timestamp units: previous event level for edge detect
      for (int v = 0; v < `PTC_NUM_TS; v++) begin
         state_next.ts[v].prev = ts_event_i[v];
      end

      // register writes
      tsel_ok = state_reg.trig_idx < 2'(`PTC_NUM_TRIG);
      if (bus_i.we) begin
         if (bus_i.addr == `PTC_OFS_UNIT_INDEX) begin
            state_next.trig_idx = bus_i.wdata[`PTC_IDX_TRIG_LSB+:2];
            state_next.ts_idx = bus_i.wdata[`PTC_IDX_TS_BIT];
         end else if (bus_i.addr == `PTC_OFS_TRIG_STATUS) begin
            irq_clr = bus_i.wdata[`PTC_TST_IRQ_LSB+:`PTC_NUM_TRIG]; // RULE20
         end else if (bus_i.addr == `PTC_OFS_CTRL_STATUS) begin
            if (tsel_ok) begin // RULE8
               if (bus_i.wdata[`PTC_CS_TRIG_CLEAR]) begin
                  state_next.tu[state_reg.trig_idx] = '0; // RULE3 RULE4
               end else if (bus_i.wdata[`PTC_CS_TRIG_ARM]) begin
                  state_next.tu[state_reg.trig_idx].en = 1'b1; // RULE1 RULE2
                  state_next.tu[state_reg.trig_idx].fresh = 1'b1;
                  state_next.tu[state_reg.trig_idx].done = 1'b0;
                  state_next.tu[state_reg.trig_idx].err = 1'b0;
               end else begin
                  state_next.tu[state_reg.trig_idx].en = 1'b0;
               end
            end
            if (bus_i.wdata[`PTC_CS_TS_CLEAR]) begin // RULE9
               state_next.ts[state_reg.ts_idx].en = 1'b0; // RULE7
               state_next.ts[state_reg.ts_idx].rdy = 1'b0;
               state_next.ts[state_reg.ts_idx].ovf = 1'b0;
               state_next.ts[state_reg.ts_idx].tally = '0;
            end else if (bus_i.wdata[`PTC_CS_TS_ARM]) begin
               state_next.ts[state_reg.ts_idx].en = 1'b1; // RULE5
               state_next.ts[state_reg.ts_idx].tally = '0;
            end else begin
               state_next.ts[state_reg.ts_idx].en = 1'b0; // RULE6
               state_next.ts[state_reg.ts_idx].rdy = 1'b0;
               state_next.ts[state_reg.ts_idx].ovf = 1'b0;
            end
         end else if (bus_i.addr == `PTC_OFS_TGT_NS) begin
            if (tsel_ok) begin
               state_next.tu[state_reg.trig_idx].tgt_ns =
                  bus_i.wdata[`PTC_NS_W-1:0]; // RULE10
            end
         end else if (bus_i.addr == `PTC_OFS_TGT_S) begin
            if (tsel_ok) begin
               state_next.tu[state_reg.trig_idx].tgt_s = bus_i.wdata; // RULE11
            end
         end else if (bus_i.addr == `PTC_OFS_CTRL_ONE) begin
            if (tsel_ok) begin
               state_next.tu[state_reg.trig_idx].cfg.chain = bus_i.wdata[`PTC_C1_CHAIN];
               state_next.tu[state_reg.trig_idx].cfg.tail = bus_i.wdata[`PTC_C1_TAIL];
               state_next.tu[state_reg.trig_idx].cfg.upsel =
                  bus_i.wdata[`PTC_C1_UPSEL_LSB+:2];
               state_next.tu[state_reg.trig_idx].cfg.late = bus_i.wdata[`PTC_C1_LATE];
               state_next.tu[state_reg.trig_idx].cfg.notify =
                  bus_i.wdata[`PTC_C1_NOTIFY];
               state_next.tu[state_reg.trig_idx].cfg.neg_edge =
                  bus_i.wdata[`PTC_C1_EDGE];
            end
         end
      end

      // hardware events after the bus write so that a set wins over a clear
      for (int u = 0; u < `PTC_NUM_TRIG; u++) begin
         if (set_done[u]) begin
            state_next.tu[u].done = 1'b1;
         end
         if (set_err[u]) begin
            state_next.tu[u].err = 1'b1;
         end
      end
      state_next.irq = (state_reg.irq & ~irq_clr) | set_done | set_err; // RULE20
      for (int v = 0; v < `PTC_NUM_TS; v++) begin
         ev = ts_event_i[v] & ~state_reg.ts[v].prev;
         if (ev && state_next.ts[v].en) begin
            state_next.ts[v].rdy = 1'b1;
            if (state_next.ts[v].tally == `PTC_TALLY_MAX) begin
               state_next.ts[v].ovf = 1'b1;
            end else begin
               state_next.ts[v].tally = state_next.ts[v].tally + 8'h01;
            end
         end
      end

      // register reads
      if (tsel_ok) begin
         tsel = state_reg.tu[state_reg.trig_idx];
      end
      ssel = state_reg.ts[state_reg.ts_idx];
      if (bus_i.re) begin
         if (bus_i.addr == `PTC_OFS_UNIT_INDEX) begin
            rd[`PTC_IDX_TRIG_LSB+:2] = state_reg.trig_idx;
            rd[`PTC_IDX_TS_BIT] = state_reg.ts_idx;
         end else if (bus_i.addr == `PTC_OFS_TRIG_STATUS) begin
            for (int u = 0; u < `PTC_NUM_TRIG; u++) begin
               rd[`PTC_TST_DONE_LSB+u] = state_reg.tu[u].done;
               rd[`PTC_TST_ERR_LSB+u] = state_reg.tu[u].err;
            end
            rd[`PTC_TST_IRQ_LSB+:`PTC_NUM_TRIG] = state_reg.irq;
         end else if (bus_i.addr == `PTC_OFS_TS_STATUS) begin
            rd[`PTC_TSS_TALLY_LSB+:`PTC_TALLY_W] = ssel.tally;
            rd[`PTC_TSS_READY] = ssel.rdy;
            rd[`PTC_TSS_OVFL] = ssel.ovf;
         end else if (bus_i.addr == `PTC_OFS_CTRL_STATUS) begin
            rd[`PTC_CS_TRIG_ACTIVE] = tsel.en;
            rd[`PTC_CS_TRIG_ARM] = tsel.en;
            rd[`PTC_CS_TS_ARM] = ssel.en;
         end else if (bus_i.addr == `PTC_OFS_TGT_NS) begin
            rd[`PTC_NS_W-1:0] = tsel.tgt_ns; // RULE10
         end else if (bus_i.addr == `PTC_OFS_TGT_S) begin
            rd = tsel.tgt_s;
         end else if (bus_i.addr == `PTC_OFS_CTRL_ONE) begin
            rd[`PTC_C1_CHAIN] = tsel.cfg.chain;
            rd[`PTC_C1_TAIL] = tsel.cfg.tail;
            rd[`PTC_C1_UPSEL_LSB+:2] = tsel.cfg.upsel;
            rd[`PTC_C1_LATE] = tsel.cfg.late;
            rd[`PTC_C1_NOTIFY] = tsel.cfg.notify;
            rd[`PTC_C1_EDGE] = tsel.cfg.neg_edge;
         end
         state_next.rdata = rd;
      end
   end

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // copy of the fire pulse retimed to the falling clock edge
   always_ff @(negedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fire_neg_reg <= '0;
      end else begin
         for (int u = 0; u < `PTC_NUM_TRIG; u++) begin
            fire_neg_reg[u] <= state_reg.tu[u].fire;
         end
      end
   end

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   always_comb begin
      for (int u = 0; u < `PTC_NUM_TRIG; u++) begin
         trig_out_o[u] = state_reg.tu[u].cfg.neg_edge ? fire_neg_reg[u]
                                                      : state_reg.tu[u].fire; // RULE18
      end
   end

   assign rdata_o = state_reg.rdata;

endmodule
`default_nettype wire

// >>> shared/ptc_defines.svh
// register offsets, field positions and reset values of the ptp trigger/timestamp block
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH
`define PTC_ADDR_W 12
`define PTC_OFS_UNIT_INDEX 12'h520
`define PTC_OFS_TRIG_STATUS 12'h524
`define PTC_OFS_TS_STATUS 12'h528
`define PTC_OFS_CTRL_STATUS 12'h52C
`define PTC_OFS_TGT_NS 12'h530
`define PTC_OFS_TGT_S 12'h534
`define PTC_OFS_CTRL_ONE 12'h538
// unit index register
`define PTC_IDX_TRIG_LSB 0
`define PTC_IDX_TS_BIT 8
// control and status register
`define PTC_CS_TRIG_ACTIVE 4
`define PTC_CS_TRIG_ARM 3
`define PTC_CS_TRIG_CLEAR 2
`define PTC_CS_TS_ARM 1
`define PTC_CS_TS_CLEAR 0
// trigger control one register
`define PTC_C1_CHAIN 31
`define PTC_C1_TAIL 30
`define PTC_C1_UPSEL_LSB 26
`define PTC_C1_LATE 25
`define PTC_C1_NOTIFY 24
`define PTC_C1_EDGE 23
// trigger status register
`define PTC_TST_DONE_LSB 0
`define PTC_TST_ERR_LSB 4
`define PTC_TST_IRQ_LSB 16
// timestamp status register
`define PTC_TSS_TALLY_LSB 0
`define PTC_TSS_READY 8
`define PTC_TSS_OVFL 9
// sizes and reset values
`define PTC_NUM_TRIG 3
`define PTC_NUM_TS 2
`define PTC_NS_W 30
`define PTC_TALLY_W 8
`define PTC_TALLY_MAX 8'hFF
`define PTC_RST_WORD 32'h00000000
`endif

// >>> shared/ptc_pkg.sv
// types of the ptp trigger/timestamp block
`include "ptc_defines.svh"
package ptc_pkg;
   typedef struct packed {
      logic [`PTC_ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } ptc_bus_req_t;

   typedef struct packed {
      logic [31:0] sec;
      logic [31:0] ns;
   } ptc_time_t;

   typedef struct packed {
      logic chain;
      logic tail;
      logic [1:0] upsel;
      logic late;
      logic notify;
      logic neg_edge;
   } ptc_trig_cfg_t;

   typedef struct packed {
      logic en;
      logic fresh;
      logic done;
      logic err;
      logic fire;
      ptc_trig_cfg_t cfg;
      logic [`PTC_NS_W-1:0] tgt_ns;
      logic [31:0] tgt_s;
   } ptc_trig_unit_t;

   typedef struct packed {
      logic en;
      logic rdy;
      logic ovf;
      logic prev;
      logic [`PTC_TALLY_W-1:0] tally;
   } ptc_ts_unit_t;

   typedef struct packed {
      ptc_trig_unit_t [`PTC_NUM_TRIG-1:0] tu;
      ptc_ts_unit_t [`PTC_NUM_TS-1:0] ts;
      logic [1:0] trig_idx;
      logic ts_idx;
      logic [`PTC_NUM_TRIG-1:0] irq;
      logic [31:0] rdata;
   } ptc_state_t;
endpackage

// >>> verif/ptc_gpio_model.sv
// time source and gpio event model facing the trigger/timestamp block
`timescale 1ns/1ps
`default_nettype none
module ptc_gpio_model
   import ptc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ld_i,
   input wire ptc_time_t ld_time_i,
   input wire logic [1:0] ev_go_i,
   output ptc_time_t ptp_time_o,
   output logic [1:0] ts_event_o
);
   // ----
   // time counter, 10 ns a cycle
   // ----
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptp_time_o <= '0;
         ts_event_o <= 2'h0;
      end else begin
         // one rising edge every two cycles while requested
         ts_event_o <= ev_go_i & ~ts_event_o;
         if (ld_i) begin
            ptp_time_o <= ld_time_i;
         end else if (ptp_time_o.ns >= 32'h3B9AC9F6) begin
            ptp_time_o.ns <= 32'h0;
            ptp_time_o.sec <= ptp_time_o.sec + 32'h1;
         end else begin
            ptp_time_o.ns <= ptp_time_o.ns + 32'hA;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verif/ptc_monitor.sv
// port checker of the ptp trigger/timestamp block
`timescale 1ns/1ps
`default_nettype none
module ptc_monitor
   import ptc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire ptc_bus_req_t bus_i,
   input wire logic [31:0] rdata_o,
   input wire ptc_time_t ptp_time_i,
   input wire logic [1:0] ts_event_i,
   input wire logic [2:0] trig_out_o
);
   // ----
   // shadow of the trigger index
   // ----
   logic [1:0] idx_reg;
   wire logic wr_cs = bus_i.we && bus_i.addr == 12'h52C;
   wire logic rd_ts = bus_i.re && bus_i.addr == 12'h528;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         idx_reg <= 2'h0;
      end else if (bus_i.we && bus_i.addr == 12'h520) begin
         idx_reg <= bus_i.wdata[1:0];
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_ns_upper_zero: assert property (
      $past(bus_i.re) && $past(bus_i.addr) == 12'h530 |-> rdata_o[31:30] == 2'h0)
      else $error("target ns upper bits set");
   a_idx_three_void: assert property (
      bus_i.re && idx_reg == 2'h3 && bus_i.addr[11:4] == 8'h53 |=> rdata_o == 32'h0)
      else $error("unit index 3 reads nonzero");
   a_ts_arm_zero: assert property (
      wr_cs && bus_i.wdata[1:0] == 2'h2 ##1 !bus_i.we ##1 rd_ts |=> rdata_o[7:0] <= 8'h01)
      else $error("tally not zeroed by arm");
   a_ts_disarm_flags: assert property (
      wr_cs && bus_i.wdata[1:0] == 2'h0 ##1 !bus_i.we ##1 rd_ts |=> rdata_o[9:8] == 2'h0)
      else $error("disarm left ready or overflow");
   a_ts_clear_all: assert property (
      wr_cs && bus_i.wdata[0] ##1 !bus_i.we ##1 rd_ts |=> rdata_o[9:0] == 10'h0)
      else $error("capture soft clear left state");
   a_trig_clear_tgt: assert property (
      wr_cs && bus_i.wdata[2] ##1 !bus_i.we
      ##1 bus_i.re && bus_i.addr == 12'h534 |=> rdata_o == 32'h0)
      else $error("trigger soft clear left target");
   a_fire_one_cycle: assert property (
      trig_out_o != 3'h0 |=> (trig_out_o & $past(trig_out_o)) == 3'h0)
      else $error("fire pulse longer than one cycle");
   a_irq_w1c_clear: assert property (
      bus_i.we && bus_i.addr == 12'h524 && bus_i.wdata[18:16] == 3'h7 && trig_out_o == 3'h0
      ##1 !bus_i.we && trig_out_o == 3'h0
      ##1 bus_i.re && bus_i.addr == 12'h524 && trig_out_o == 3'h0 ##1 trig_out_o == 3'h0
      |-> rdata_o[18:16] == 3'h0) else $error("irq status not cleared");
endmodule
bind ptc_top ptc_monitor u_mon (.sys_clk_i, .rst_i, .bus_i, .rdata_o, .ptp_time_i,
   .ts_event_i, .trig_out_o);
`default_nettype wire

// >>> verif/test_ptp_event_trigger_timestamp_ctrl.sv
// self-checking bench of the ptp trigger/timestamp block
`timescale 1ns/1ps
`default_nettype none
module test_ptp_event_trigger_timestamp_ctrl
   import ptc_pkg::*;
;
   logic sys_clk_i;
   logic rst_i;
   logic ld;
   ptc_bus_req_t bus;
   ptc_time_t ptp_time;
   ptc_time_t ld_time;
   logic [31:0] rdata;
   logic [1:0] ts_ev;
   logic [1:0] ev_go;
   logic [2:0] trig_out;
   logic [2:0] seen;
   int err_count;
   int n_checks;
   int n;
   int first;
   ptc_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
      .ptp_time_i(ptp_time), .ts_event_i(ts_ev), .trig_out_o(trig_out));
   ptc_gpio_model u_gpio (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ld_i(ld),
      .ld_time_i(ld_time), .ev_go_i(ev_go), .ptp_time_o(ptp_time), .ts_event_o(ts_ev));
   // ----
   // tasks
   // ----
   task automatic complete_run();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // an idle cycle closes every access, so a following call never reassigns bus in one step
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge sys_clk_i);
      bus <= '0;
      @(posedge sys_clk_i);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge sys_clk_i);
      bus <= '0;
      @(negedge sys_clk_i);
      chk(rdata, e);
      @(posedge sys_clk_i);
   endtask
   task automatic set_time(input logic [31:0] s, input logic [31:0] ns);
      ld_time <= '{sec: s, ns: ns};
      ld <= 1'b1;
      @(posedge sys_clk_i);
      ld <= 1'b0;
   endtask
   task automatic pulse(input logic [1:0] g, input int k);
      ev_go <= g;
      repeat (k) @(posedge sys_clk_i);
      ev_go <= 2'h0;
   endtask
   // collects fired units, fire cycles and the first fire cycle
   task automatic watch(input int k);
      seen = 3'h0;
      n = 0;
      first = 0;
      for (int i = 1; i <= k; i++) begin
         #1;
         seen |= trig_out;
         n += int'(trig_out != 3'h0);
         if (trig_out != 3'h0 && first == 0) first = i;
         @(posedge sys_clk_i);
      end
   endtask
   // ----
   // clock, watchdog, tests
   // ----
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #50000;
      err_count++;
      complete_run();
   end
   initial begin
      rst_i = 1'b1;
      bus = '0;
      ld = 1'b0;
      ld_time = '0;
      ev_go = 2'h0;
      err_count = 0;
      n_checks = 0;
      repeat (5) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      rd(12'h530, 32'h0);
      rd(12'h534, 32'h0);
      rd(12'h5FC, 32'h0);
      wr(12'h530, 32'hFFFFFFFF);
      rd(12'h530, 32'h3FFFFFFF);
      wr(12'h534, 32'hFFFFFFFF);
      wr(12'h538, 32'hFFFFFFFF);
      rd(12'h538, 32'hCF800000);
      wr(12'h520, 32'h1);
      rd(12'h534, 32'h0);
      wr(12'h520, 32'h3);
      wr(12'h534, 32'h5);
      rd(12'h534, 32'h0);
      wr(12'h520, 32'h0);
      rd(12'h534, 32'hFFFFFFFF);
      wr(12'h52C, 32'h4);
      rd(12'h534, 32'h0);
      rd(12'h538, 32'h0);
      set_time(32'h5, 32'h0);
      wr(12'h534, 32'h1);
      wr(12'h538, 32'h03000000);
      wr(12'h52C, 32'h8);
      watch(10);
      chk({29'h0, seen}, 32'h1);
      rd(12'h52C, 32'h0);
      rd(12'h524, 32'h00010001);
      wr(12'h524, 32'h00070000);
      rd(12'h524, 32'h00000001);
      wr(12'h538, 32'h01000000);
      wr(12'h52C, 32'h8);
      watch(10);
      chk({29'h0, seen}, 32'h0);
      rd(12'h524, 32'h00010010);
      wr(12'h524, 32'h00070000);
      set_time(32'h0, 32'h3B9AC99C);
      wr(12'h530, 32'h14);
      wr(12'h538, 32'h00800000);
      wr(12'h52C, 32'h8);
      watch(30);
      chk(first, 32'h9);
      chk({29'h0, seen}, 32'h1);
      rd(12'h524, 32'h0);
      wr(12'h52C, 32'h4);
      wr(12'h538, 32'h8A000000);
      wr(12'h520, 32'h1);
      wr(12'h538, 32'hC6000000);
      wr(12'h520, 32'h0);
      wr(12'h52C, 32'h8);
      watch(20);
      chk({29'h0, seen}, 32'h3);
      chk(n, 32'h2);
      wr(12'h538, 32'h8A000000);
      wr(12'h520, 32'h1);
      wr(12'h538, 32'h86000000);
      wr(12'h520, 32'h0);
      wr(12'h52C, 32'h8);
      watch(40);
      chk({31'h0, n > 4}, 32'h1);
      wr(12'h52C, 32'h4);
      watch(10);
      watch(30);
      chk(n, 32'h0);
      wr(12'h520, 32'h100);
      wr(12'h52C, 32'h2);
      pulse(2'h3, 6);
      rd(12'h528, 32'h103);
      rd(12'h52C, 32'h2);
      wr(12'h520, 32'h0);
      rd(12'h528, 32'h0);
      wr(12'h520, 32'h100);
      pulse(2'h2, 520);
      rd(12'h528, 32'h3FF);
      wr(12'h52C, 32'h2);
      rd(12'h528, 32'h300);
      wr(12'h52C, 32'h0);
      rd(12'h528, 32'h0);
      wr(12'h52C, 32'h2);
      pulse(2'h2, 2);
      wr(12'h52C, 32'h1);
      rd(12'h528, 32'h0);
      rd(12'h52C, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
